// >>> common/lstc_pkg.sv
/*
  Package for the line start trigger control block: widths, field encodings,
  reset values, timing constants, state enum and the packed config carrier.
  Assumes a single 200 MHz reference clock.
*/
package lstc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int TICK_NS         = 100;
  localparam int CYC_PER_TICK    = (TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam int TICK_CNT_W      = 8;
  localparam int EXP_CNT_W       = 20;
  localparam int PER_CNT_W       = 24;
  localparam int MIN_LINE_TICKS  = 1;

  // ----------------------------------------
  // Field encodings and resets
  // ----------------------------------------
  localparam logic MODE_OFF       = 1'b0;
  localparam logic MODE_ON        = 1'b1;
  localparam logic ORIGIN_SOFT    = 1'b0;
  localparam logic ORIGIN_HW      = 1'b1;
  localparam logic EXPMODE_TIMED  = 1'b0;
  localparam logic EXPMODE_WIDTH  = 1'b1;
  localparam logic [EXP_CNT_W-1:0] EXP_RST = 20'h003E8;
  localparam logic [PER_CNT_W-1:0] PER_RST = 24'h0003E8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LSTC_WAIT     = 2'b00,
    LSTC_EXPOSE   = 2'b01,
    LSTC_RECOVER  = 2'b10
  } lstc_state_e;

  typedef struct packed {
    logic                 line_trigger_mode;
    logic                 line_trigger_origin;
    logic                 exposure_timing_mode;
    logic                 internal_rate_gate;
    logic [EXP_CNT_W-1:0] exposure_duration_us;
    logic [PER_CNT_W-1:0] internal_rate_target;
  } lstc_cfg_s;

endpackage

// >>> rtl/lstc_down_cnt.sv
/*
  Tick-driven down counter with load; flags zero.
  Assumes load and tick come from the same clock domain.
*/
`timescale 1ns/1ps
module lstc_down_cnt #(
  parameter int W = 24
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  // Status
  output logic              zero
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // ----------------------------------------
  // Count
  // ----------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (tick && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign zero = (cnt_ff == '0);

endmodule

// >>> rtl/lstc_tick.sv
/*
  Time base tick generator: one-cycle pulse every 100 ns.
  Assumes REF_CLK at the rate set in the package.
*/
`timescale 1ns/1ps
module lstc_tick
  import lstc_pkg::*;
#(
  parameter int DIV = CYC_PER_TICK
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Tick out
  output logic      tick
);

  logic [TICK_CNT_W-1:0] cnt_ff;
  logic [TICK_CNT_W-1:0] nxt_cnt;
  logic                  tick_ff;
  logic                  nxt_tick;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt  = cnt_ff + 8'h01;
    if (cnt_ff == TICK_CNT_W'(DIV - 1)) begin
      nxt_cnt  = 8'h00;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff & ce;

endmodule

// >>> rtl/lstc_top.sv
/*
  Line start trigger control: internal line period timer, software trigger
  command, timed exposure and waiting-for-trigger status.
  Assumes configuration ports are held stable by host logic, synchronous
  to REF_CLK.
*/
`timescale 1ns/1ps

// What this block does
// - Every timing count is unsigned ticks of 100 ns each.
// - Rate gate one in mode Off makes the block generate its own line triggers.
// - Internal lines repeat at one per programmed period count.
// - Rate gate zero stops the internal timer, so mode Off starts no lines; software triggers set rate in mode On.
// - Software trigger while waiting starts a line exposure.
// - Exposure start leaves waiting; waiting returns once ready again.
// - Each accepted software trigger starts exactly one line.
// - Software triggers arriving while busy are dropped, never queued; an internal period elapse is held until waiting.
// - Writing one to the command applies a trigger in mode On with software origin; the command self-clears in every mode.
// - Waiting flag reads one when a trigger can be accepted.
// - Mode Off with rate gate one triggers internally; rate is capped at the maximum.
module lstc_top
  import lstc_pkg::*;
#(
  parameter int EXP_W      = EXP_CNT_W,
  parameter int PER_W      = PER_CNT_W,
  parameter int RECOVER_TK = MIN_LINE_TICKS
) (
  // Clock, reset, enable
  input  wire logic       REF_CLK,
  input  wire logic       RSTN,
  input  wire logic       CE,
  // Configuration
  input  wire lstc_cfg_s  CFG,
  // Software trigger command write
  input  wire logic       SOFT_TRIGGER_WR,
  input  wire logic       SOFT_TRIGGER_DATA,
  // Status
  output logic            SOFT_TRIGGER_COMMAND,
  output logic            AWAITING_TRIGGER_FLAG,
  output logic            LINE_START,
  output logic            EXPOSING,
  output logic            TRIGGER_DROPPED
);

  lstc_state_e        state_ff;
  lstc_state_e        nxt_state;
  logic               cmd_ff;
  logic               nxt_cmd;
  logic               wait_ff;
  logic               nxt_wait;
  logic               start_ff;
  logic               nxt_start;
  logic               expo_ff;
  logic               nxt_expo;
  logic               drop_ff;
  logic               nxt_drop;
  logic [7:0]         rec_ff;
  logic [7:0]         nxt_rec;
  logic               tick;
  logic               exp_zero;
  logic               per_zero;
  logic               per_load;
  logic               exp_load;
  logic               per_due_ff;
  logic               nxt_per_due;
  logic               soft_req;
  logic               int_req;
  logic               req;
  logic               accept;
  logic [PER_W-1:0]   per_val;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [PER_W-1:0] clamp_period(input logic [PER_W-1:0] p);
    if (p < PER_W'(MIN_LINE_TICKS)) begin
      clamp_period = PER_W'(MIN_LINE_TICKS);
    end else begin
      clamp_period = p;
    end
  endfunction

  // ----------------------------------------
  // Time base and counters
  // ----------------------------------------
  lstc_tick u_tick (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .ce    (CE),
    .tick  (tick)
  );

  lstc_down_cnt #(.W(EXP_W)) u_exp (
    .clk      (REF_CLK),
    .rst_n    (RSTN),
    .ce       (CE),
    .load     (exp_load),
    .load_val (CFG.exposure_duration_us[EXP_W-1:0]),
    .tick     (tick),
    .zero     (exp_zero)
  );

  lstc_down_cnt #(.W(PER_W)) u_per (
    .clk      (REF_CLK),
    .rst_n    (RSTN),
    .ce       (CE),
    .load     (per_load),
    .load_val (per_val),
    .tick     (tick),
    .zero     (per_zero)
  );

  // ----------------------------------------
  // Trigger sources
  // ----------------------------------------
  assign per_val  = clamp_period(CFG.internal_rate_target[PER_W-1:0]);
  assign soft_req = SOFT_TRIGGER_WR && SOFT_TRIGGER_DATA
                    && CFG.line_trigger_mode == MODE_ON
                    && CFG.line_trigger_origin == ORIGIN_SOFT;
  assign int_req  = CFG.line_trigger_mode == MODE_OFF
                    && CFG.internal_rate_gate && per_due_ff;
  assign req      = soft_req | int_req;
  assign accept   = req && state_ff == LSTC_WAIT;
  assign exp_load = accept;
  assign per_load = accept | (per_due_ff & ~int_req) | ~CFG.internal_rate_gate;

  // ----------------------------------------
  // Period elapse latch
  // ----------------------------------------
  always_comb begin
    nxt_per_due = per_due_ff;
    if (accept || !CFG.internal_rate_gate) begin
      nxt_per_due = 1'b0;
    end else if (per_zero && !per_load) begin
      nxt_per_due = 1'b1;
    end
  end

  // ----------------------------------------
  // Line state machine
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_rec   = rec_ff;
    nxt_start = 1'b0;
    nxt_drop  = 1'b0;
    nxt_cmd   = cmd_ff;
    unique case (state_ff)
      LSTC_WAIT: begin
        if (accept) begin
          nxt_state = LSTC_EXPOSE;
          nxt_start = 1'b1;
        end
      end
      LSTC_EXPOSE: begin
        if (soft_req) begin
          nxt_drop = 1'b1;
        end
        if (exp_zero && !exp_load) begin
          nxt_state = LSTC_RECOVER;
          nxt_rec   = 8'(RECOVER_TK);
        end
      end
      LSTC_RECOVER: begin
        if (soft_req) begin
          nxt_drop = 1'b1;
        end
        if (rec_ff == 8'h00) begin
          nxt_state = LSTC_WAIT;
        end else if (tick) begin
          nxt_rec = rec_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = LSTC_WAIT;
      end
    endcase
    // Command reads one for the cycle after a write of one, then clears
    if (SOFT_TRIGGER_WR && SOFT_TRIGGER_DATA) begin
      nxt_cmd = 1'b1;
    end else if (cmd_ff) begin
      nxt_cmd = 1'b0;
    end
    nxt_wait = (nxt_state == LSTC_WAIT);
    nxt_expo = (nxt_state == LSTC_EXPOSE);
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state_ff   <= LSTC_WAIT;
      rec_ff     <= 8'h00;
      start_ff   <= 1'b0;
      drop_ff    <= 1'b0;
      cmd_ff     <= 1'b0;
      wait_ff    <= 1'b1;
      expo_ff    <= 1'b0;
      per_due_ff <= 1'b0;
    end else if (CE) begin
      state_ff   <= nxt_state;
      rec_ff     <= nxt_rec;
      start_ff   <= nxt_start;
      drop_ff    <= nxt_drop;
      cmd_ff     <= nxt_cmd;
      wait_ff    <= nxt_wait;
      expo_ff    <= nxt_expo;
      per_due_ff <= nxt_per_due;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign SOFT_TRIGGER_COMMAND  = cmd_ff;
  assign AWAITING_TRIGGER_FLAG = wait_ff;
  assign LINE_START            = start_ff;
  assign EXPOSING              = expo_ff;
  assign TRIGGER_DROPPED       = drop_ff;

endmodule

// >>> verif/lstc_asserts.sv
/*
  Port checker for lstc_top, bound below.
  Assumes checks pause while CE is low; exposure length counts enabled cycles.
*/
`timescale 1ns/1ps
module lstc_asserts
  import lstc_pkg::*;
(
  // Inputs
  input wire logic      REF_CLK,
  input wire logic      RSTN,
  input wire logic      CE,
  input wire lstc_cfg_s CFG,
  input wire logic      SOFT_TRIGGER_WR,
  input wire logic      SOFT_TRIGGER_DATA,
  // Outputs
  input wire logic      SOFT_TRIGGER_COMMAND,
  input wire logic      AWAITING_TRIGGER_FLAG,
  input wire logic      LINE_START,
  input wire logic      EXPOSING,
  input wire logic      TRIGGER_DROPPED
);
  // ----------------------------------------
  // Exposure length counter
  // ----------------------------------------
  int   exp_cyc_ff;
  int   nxt_exp_cyc;
  int   exp_cyc;
  logic soft_req;
  always_comb begin
    nxt_exp_cyc = EXPOSING ? exp_cyc_ff + int'(CE) : 0;
    exp_cyc     = int'(CFG.exposure_duration_us) * CYC_PER_TICK;
    soft_req    = CE && SOFT_TRIGGER_WR && SOFT_TRIGGER_DATA
                  && CFG.line_trigger_mode == MODE_ON
                  && CFG.line_trigger_origin == ORIGIN_SOFT;
  end
  always_ff @(posedge REF_CLK) begin
    exp_cyc_ff <= RSTN ? nxt_exp_cyc : 0;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN || !CE);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  soft_accept_a: assert property (soft_req && AWAITING_TRIGGER_FLAG |=> LINE_START && SOFT_TRIGGER_COMMAND)
    else $error("soft trigger not accepted");
  busy_drop_a: assert property (soft_req && !AWAITING_TRIGGER_FLAG |=> TRIGGER_DROPPED && !LINE_START)
    else $error("busy trigger not dropped");
  start_leaves_wait_a: assert property (LINE_START |-> !AWAITING_TRIGGER_FLAG && EXPOSING)
    else $error("line start while still waiting");
  cmd_self_clear_a: assert property (SOFT_TRIGGER_COMMAND |=> !SOFT_TRIGGER_COMMAND)
    else $error("command did not self clear");
  wait_not_busy_a: assert property (AWAITING_TRIGGER_FLAG |-> !EXPOSING)
    else $error("waiting flag high during exposure");
  soft_only_a: assert property (CFG.line_trigger_mode == MODE_ON && LINE_START |-> $past(soft_req))
    else $error("line start without software trigger");
  exp_length_a: assert property ($fell(EXPOSING) |-> exp_cyc_ff <= exp_cyc + CYC_PER_TICK && exp_cyc_ff + CYC_PER_TICK >= exp_cyc)
    else $error("exposure length off");
  recover_wait_a: assert property ($fell(EXPOSING) |-> !AWAITING_TRIGGER_FLAG ##[1:45] AWAITING_TRIGGER_FLAG)
    else $error("waiting flag did not return");
  cover property (LINE_START);
  cover property (TRIGGER_DROPPED);
  cover property ($fell(EXPOSING));
endmodule
bind lstc_top lstc_asserts u_lstc_asserts (.REF_CLK(REF_CLK), .RSTN(RSTN), .CE(CE), .CFG(CFG),
  .SOFT_TRIGGER_WR(SOFT_TRIGGER_WR), .SOFT_TRIGGER_DATA(SOFT_TRIGGER_DATA),
  .SOFT_TRIGGER_COMMAND(SOFT_TRIGGER_COMMAND), .AWAITING_TRIGGER_FLAG(AWAITING_TRIGGER_FLAG),
  .LINE_START(LINE_START), .EXPOSING(EXPOSING), .TRIGGER_DROPPED(TRIGGER_DROPPED));

// >>> verif/lstc_host_model.sv
/*
  Host model: configuration levels and command writes.
  Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module lstc_host_model
  import lstc_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Host side
  output lstc_cfg_s cfg,
  output logic      wr,
  output logic      data
);
  initial begin
    cfg  = '0;
    wr   = 1'b0;
    data = 1'b0;
  end
  task automatic set_cfg(input logic mode, input logic org, input logic gate,
                         input int exp, input int per);
    @(posedge clk);
    cfg.line_trigger_mode    <= mode;
    cfg.line_trigger_origin  <= org;
    cfg.exposure_timing_mode <= EXPMODE_TIMED;
    cfg.internal_rate_gate   <= gate;
    cfg.exposure_duration_us <= EXP_CNT_W'(exp);
    cfg.internal_rate_target <= PER_CNT_W'(per);
  endtask
  task automatic soft_write(input logic d);
    @(posedge clk);
    wr   <= 1'b1;
    data <= d;
    @(posedge clk);
    wr   <= 1'b0;
  endtask
endmodule

// >>> verif/tb.sv
/*
  Self-checking bench for lstc_top.
  Assumes 200 MHz clock and 20 cycles per tick.
*/
`timescale 1ns/1ps
module tb;
  import lstc_pkg::*;
  logic      clk;
  logic      rstn;
  logic      ce;
  lstc_cfg_s cfg;
  logic      wr;
  logic      data;
  logic      cmd;
  logic      flag;
  logic      ls;
  logic      expo;
  logic      drop;
  int        error_cnt;
  int        n_compared;
  int        lines;
  int        exp_lines;
  int        n;
  int        c;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  lstc_host_model u_lstc_host_model (.clk(clk), .cfg(cfg), .wr(wr), .data(data));
  lstc_top u_lstc_top (.REF_CLK(clk), .RSTN(rstn), .CE(ce), .CFG(cfg), .SOFT_TRIGGER_WR(wr),
    .SOFT_TRIGGER_DATA(data), .SOFT_TRIGGER_COMMAND(cmd), .AWAITING_TRIGGER_FLAG(flag),
    .LINE_START(ls), .EXPOSING(expo), .TRIGGER_DROPPED(drop));
  always @(posedge clk) begin
    if (ls === 1'b1) lines++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("Compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_ls(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (ls !== 1'b1 && k < 2000);
  endtask
  task automatic soft_line(input int t);
    u_lstc_host_model.soft_write(1'b1);
    #1;
    exp_lines++;
    chk("line_start", 1, ls);
    chk("command", 1, cmd);
    chk("wait_flag", 0, flag);
    for (c = 0; expo === 1'b1 && c < 600; c++) begin
      @(posedge clk);
      #1;
    end
    chk("exposure", 1, c + 21 > t * CYC_PER_TICK && c < t * CYC_PER_TICK + 21);
    for (c = 0; flag !== 1'b1 && c < 700; c++) #5;
    chk("wait_flag", 1, flag);
    chk("command", 0, cmd);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    ce = 1'b1;
    rstn = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    lines = 0;
    exp_lines = 0;
    n = $urandom(32'h86D6B478);
    @(posedge clk);
    #1;
    chk("rst_flag", 1, flag);
    chk("rst_outs", 0, {cmd, ls, expo, drop});
    @(posedge clk);
    rstn <= 1'b1;
    $display("Test reset done");
    for (int i = 0; i < 3; i++) begin
      n = 20 + $urandom % 5;
      u_lstc_host_model.set_cfg(MODE_ON, ORIGIN_SOFT, 1'b0, n, 8);
      soft_line(n);
    end
    chk("lines", exp_lines, lines);
    $display("Test soft trigger done");
    u_lstc_host_model.soft_write(1'b1);
    u_lstc_host_model.soft_write(1'b1);
    #1;
    chk("dropped", 1, drop);
    chk("busy_start", 0, ls);
    for (c = 0; flag !== 1'b1 && c < 800; c++) #5;
    chk("no_queue", exp_lines + 1, lines);
    exp_lines++;
    u_lstc_host_model.soft_write(1'b0);
    #1;
    chk("zero_write", 0, ls);
    $display("Test overtrigger done");
    u_lstc_host_model.set_cfg(MODE_OFF, ORIGIN_SOFT, 1'b0, 20, 8);
    u_lstc_host_model.soft_write(1'b1);
    u_lstc_host_model.set_cfg(MODE_ON, ORIGIN_HW, 1'b0, 20, 8);
    u_lstc_host_model.soft_write(1'b1);
    #1;
    chk("cmd_set", 1, cmd);
    @(posedge clk);
    #1;
    chk("cmd_clear", 0, cmd);
    repeat (400) @(posedge clk);
    chk("ignored", exp_lines, lines);
    $display("Test ignored writes done");
    n = 30 + $urandom % 10;
    u_lstc_host_model.set_cfg(MODE_OFF, ORIGIN_SOFT, 1'b1, 20, n);
    wait_ls(c);
    chk("first_line", 1, c < 2000);
    for (int i = 0; i < 2; i++) begin
      wait_ls(c);
      chk("period", 1, c + 21 > n * CYC_PER_TICK && c < n * CYC_PER_TICK + 21);
    end
    @(posedge clk);
    ce <= 1'b0;
    #1;
    exp_lines = lines;
    n = {flag, expo};
    repeat (1000) @(posedge clk);
    #1;
    chk("ce_hold", n, {flag, expo});
    chk("ce_lines", exp_lines, lines);
    @(posedge clk);
    ce <= 1'b1;
    wait_ls(c);
    chk("ce_resume", 1, c < 2000);
    u_lstc_host_model.set_cfg(MODE_OFF, ORIGIN_SOFT, 1'b1, 20, 0);
    wait_ls(c);
    wait_ls(c);
    chk("max_rate", 1, c > 20 * CYC_PER_TICK && c < 2000);
    u_lstc_host_model.set_cfg(MODE_OFF, ORIGIN_SOFT, 1'b0, 20, 8);
    repeat (600) @(posedge clk);
    exp_lines = lines;
    repeat (1000) @(posedge clk);
    chk("gate_off", exp_lines, lines);
    $display("Test free run done");
    end_of_test;
  end
endmodule
